//--- drv_model.sv
// Host driver model issuing command and data cycles
`timescale 1ns/1ns
`default_nettype none
module drv_model (
   input  wire logic        ref_clk,
   output var  logic        cmd_valid = 1'b0,
   output var  logic [7:0]  cmd_code = 8'h00,
   output var  logic        wr_valid = 1'b0,
   output var  logic [15:0] wr_data = 16'h0000,
   output var  logic        rd_valid = 1'b0,
   input  wire logic [15:0] rd_data
);
   task automatic send_cmd(input logic [7:0] code);
      @(posedge ref_clk) cmd_valid <= 1'b1;
      cmd_code <= code;
      @(posedge ref_clk) cmd_valid <= 1'b0;
   endtask
   // Low half first; commit lands on the high half
   task automatic reg_write(input logic [7:0] code, input logic [31:0] d);
      send_cmd(code);
      wr_valid <= 1'b1;
      wr_data <= d[15:0];
      @(posedge ref_clk) wr_data <= d[31:16];
      @(posedge ref_clk) wr_valid <= 1'b0;
      wr_data <= ~d[31:16];
   endtask
   task automatic reg_read(input logic [7:0] code, output logic [31:0] d);
      send_cmd(code);
      rd_valid <= 1'b1;
      @(posedge ref_clk) #1 d[15:0] = rd_data;
      @(posedge ref_clk) rd_valid <= 1'b0;
      #1 d[31:16] = rd_data;
   endtask
endmodule // drv_model
`default_nettype wire

//--- hc_ctrl_defines.vh
// Constants for the host operating mode control block
`ifndef HC_CTRL_DEFINES_VH
`define HC_CTRL_DEFINES_VH

// Command codes on the microprocessor bus
`define CMD_CTRL_READ       8'h01
`define CMD_CTRL_WRITE      8'h81

// Field positions of the control register
`define WAKE_EN_BIT         10
`define WAKE_CONN_BIT       9
`define FSTATE_HI           7
`define FSTATE_LO           6

// Functional state encodings
`define STATE_RESET         2'h0
`define STATE_RESUME        2'h1
`define STATE_OPERATIONAL   2'h2
`define STATE_SUSPEND       2'h3

// Reset values
`define CTRL_RESET_VAL      32'h0000_0000
`define FSTATE_RESET_VAL    2'h0

// Timing: 1 ms of 20 ns clock cycles
`define SOF_DELAY_CYCLES    17'h0c350
`define SOF_CNT_W           17

`endif

//--- host_mode_control.v
// Host operating mode control register and functional state logic
// Function
// - Hardware or software reset puts functional state field to reset, 00B.
// - Hardware reset alone resets root hub, then signals reset downstream.
// - Entering operational from another state starts frames 1 ms later.
// - Device changes functional state itself only while in suspend.
// - In suspend, downstream resume signaling moves state to resume.
// - Wakeup enable plus resume-detected flag signals remote wakeup to system.
// - Wakeup enable has no effect on hardware interrupt generation.
// - Wakeup connected bit cleared by hardware reset, kept on software reset.
// - Control register read with command 01H, written with command 81H.
`timescale 1ns/1ns
`default_nettype none
`include "hc_ctrl_defines.vh"

module host_mode_control #(
   parameter [`SOF_CNT_W-1:0] SOF_DELAY_CYCLES = `SOF_DELAY_CYCLES
) (
   input  wire        ref_clk,
   input  wire        nrst,

   input  wire        cmd_valid,
   input  wire [7:0]  cmd_code,
   input  wire        wr_valid,
   input  wire [15:0] wr_data,
   input  wire        rd_valid,
   output reg  [15:0] rd_data,

   input  wire        sw_reset,
   input  wire        downstream_resume,
   input  wire        resume_detected_flag,

   output wire        remote_wakeup,
   output reg         sof_start,
   output reg         sof_active,

   output wire        root_hub_reset,
   output wire        port_reset_signal,
   output wire [1:0]  host_functional_state
);

   localparam [1:0] HW_HUB  = 2'h0;
   localparam [1:0] HW_PORT = 2'h1;
   localparam [1:0] HW_DONE = 2'h2;

   reg  [1:0]  functional_state_field_r;
   reg  [1:0]  functional_state_field_nxt;
   reg         remote_wakeup_enable_r;
   reg         remote_wakeup_connected_r;
   reg  [7:0]  cmd_r;
   reg         half_r;
   reg  [15:0] wr_low_r;
   reg  [1:0]  hw_seq_r;
   reg  [1:0]  hw_seq_nxt;

   wire [31:0] ctrl_read;
   wire        ctrl_commit;
   wire [31:0] ctrl_wr_word;
   wire        enter_oper;
   wire        leave_oper;
   wire        sof_due;

   // Decodes shared by several processes
   wire        in_suspend;
   wire        oper_nxt;
   wire        wr_ctrl_sel;
   wire        rd_ctrl_sel;
   wire        data_strobe;
   wire        resume_move;

   // Reserved bits are not stored, so they can only read as zero
   function [31:0] pack_ctrl;
      input [1:0] fs;
      input       remote_wakeup_enable;
      input       remote_wakeup_connected;
      begin
         pack_ctrl = `CTRL_RESET_VAL;
         pack_ctrl[`FSTATE_HI:`FSTATE_LO] = fs;
         pack_ctrl[`WAKE_EN_BIT] = remote_wakeup_enable;
         pack_ctrl[`WAKE_CONN_BIT] = remote_wakeup_connected;
      end
   endfunction

   assign ctrl_read = pack_ctrl(functional_state_field_r, remote_wakeup_enable_r,
                                remote_wakeup_connected_r);

   // 32-bit word moves as two 16-bit halves, low half first
   assign wr_ctrl_sel  = (cmd_r == `CMD_CTRL_WRITE);
   assign rd_ctrl_sel  = (cmd_r == `CMD_CTRL_READ);
   assign data_strobe  = wr_valid || rd_valid;
   // A lone low half never commits, so a cut write leaves the register alone
   assign ctrl_commit  = wr_valid && half_r && wr_ctrl_sel;
   assign ctrl_wr_word = {wr_data, wr_low_r};

   // Command and data phase tracking
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_r    <= 8'h00;
         half_r   <= 1'b0;
         wr_low_r <= 16'h0000;
      end else begin
         // Command wins over a coinciding strobe and restarts at the low half
         if (cmd_valid) begin
            cmd_r  <= cmd_code;
            half_r <= 1'b0;
         end else if (data_strobe) begin
            half_r <= ~half_r;
         end
         if (wr_valid && !half_r) begin
            wr_low_r <= wr_data;
         end
      end
   end

   // Unmapped commands read as zero; data holds until the next read strobe
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= 16'h0000;
      end else if (rd_valid) begin
         if (rd_ctrl_sel) begin
            rd_data <= half_r ? ctrl_read[31:16] : ctrl_read[15:0];
         end else begin
            rd_data <= 16'h0000;
         end
      end
   end

   // Driver write wins over an autonomous move in the same cycle
   always @* begin
      functional_state_field_nxt = functional_state_field_r;
      if (sw_reset) begin
         functional_state_field_nxt = `STATE_RESET;
      end else if (ctrl_commit) begin
         functional_state_field_nxt = ctrl_wr_word[`FSTATE_HI:`FSTATE_LO];
      end else if (resume_move) begin
         functional_state_field_nxt = `STATE_RESUME;
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         functional_state_field_r  <= `FSTATE_RESET_VAL;
         remote_wakeup_enable_r    <= 1'b0;
         remote_wakeup_connected_r <= 1'b0;
      end else begin
         functional_state_field_r <= functional_state_field_nxt;
         if (sw_reset) begin
            // Connected bit survives a software reset
            remote_wakeup_enable_r <= 1'b0;
         end else if (ctrl_commit) begin
            remote_wakeup_enable_r    <= ctrl_wr_word[`WAKE_EN_BIT];
            remote_wakeup_connected_r <= ctrl_wr_word[`WAKE_CONN_BIT];
         end
      end
   end

   // No interrupt path here: wakeup goes only to the system side
   assign remote_wakeup = remote_wakeup_enable_r && resume_detected_flag;
   assign host_functional_state = functional_state_field_r;

   // Only suspend lets the state move without a driver write
   assign in_suspend  = (functional_state_field_r == `STATE_SUSPEND);
   assign resume_move = in_suspend && downstream_resume;
   assign oper_nxt    = (functional_state_field_nxt == `STATE_OPERATIONAL);

   // Rewriting operational while in it does not restart the frame delay
   assign enter_oper = oper_nxt && (functional_state_field_r != `STATE_OPERATIONAL);
   assign leave_oper = !oper_nxt;

   sof_delay_timer #(
      .DELAY_CYCLES (SOF_DELAY_CYCLES)
   ) sof_delay_timer_inst (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .start   (enter_oper),
      .cancel  (leave_oper),
      .done    (sof_due)
   );

   // Pulse feeds the start-of-frame flag the driver polls
   // Cancel wins over expiry, so a late leave never shows a frame start
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sof_start  <= 1'b0;
         sof_active <= 1'b0;
      end else begin
         sof_start <= sof_due && !leave_oper;
         if (leave_oper) begin
            sof_active <= 1'b0;
         end else if (sof_due) begin
            sof_active <= 1'b1;
         end
      end
   end

   // Hardware reset only: hub reset, then downstream reset signaling
   // One cycle each; a longer downstream reset would need its own counter
   always @* begin
      case (hw_seq_r)
         HW_HUB:  hw_seq_nxt = HW_PORT;
         HW_PORT: hw_seq_nxt = HW_DONE;
         HW_DONE: hw_seq_nxt = HW_DONE;
         default: hw_seq_nxt = HW_DONE;
      endcase
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hw_seq_r <= HW_HUB;
      end else begin
         hw_seq_r <= hw_seq_nxt;
      end
   end

   // Software reset never touches this sequence
   assign root_hub_reset    = (hw_seq_r == HW_HUB);
   assign port_reset_signal = (hw_seq_r == HW_PORT);

endmodule // host_mode_control
`default_nettype wire

//--- host_mode_control_properties.sv
// Port assertions for the host mode control block
`timescale 1ns/1ns
`default_nettype none
module host_mode_control_properties #(
   parameter [16:0] SOF_DELAY_CYCLES = 17'h0c350
) (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       wr_valid,
   input wire logic       sw_reset,
   input wire logic       downstream_resume,
   input wire logic       resume_detected_flag,
   input wire logic       remote_wakeup,
   input wire logic       sof_start,
   input wire logic       root_hub_reset,
   input wire logic       port_reset_signal,
   input wire logic [1:0] host_functional_state
);
   localparam int DLY = SOF_DELAY_CYCLES;
   int op_cnt;
   // Cycles spent in operational, held once past the frame start point
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) op_cnt <= 0;
      else if (host_functional_state != 2'b10) op_cnt <= 0;
      else if (op_cnt <= DLY + 1) op_cnt <= op_cnt + 1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_wake_needs_flag: assert property (remote_wakeup |-> resume_detected_flag)
      else $error("wakeup without resume flag");
   a_sw_reset_state: assert property (sw_reset |=> host_functional_state == 2'b00)
      else $error("state not reset by sw reset");
   a_hw_reset_state: assert property ($rose(nrst) |-> host_functional_state == 2'b00)
      else $error("state not reset by hw reset");
   a_hub_then_port: assert property ($fell(root_hub_reset) |-> port_reset_signal)
      else $error("port reset missing after hub reset");
   a_port_one_cycle: assert property (port_reset_signal |=> !port_reset_signal)
      else $error("port reset too long");
   a_sof_in_op: assert property (sof_start |-> host_functional_state == 2'b10)
      else $error("frame start outside operational");
   a_sof_delay: assert property (op_cnt == DLY + 1 && host_functional_state == 2'b10
      |-> sof_start) else $error("frame start late");
   a_sof_early: assert property (sof_start |-> op_cnt == DLY + 1)
      else $error("frame start early");
   a_resume_move: assert property (host_functional_state == 2'b11 && downstream_resume
      && !wr_valid && !sw_reset |=> host_functional_state == 2'b01) else $error("no resume");
   a_state_hold: assert property (host_functional_state != 2'b11 && !wr_valid && !sw_reset
      |=> $stable(host_functional_state)) else $error("state moved by itself");
endmodule // host_mode_control_properties
bind host_mode_control host_mode_control_properties #(.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES))
   chk_inst (.ref_clk(ref_clk), .nrst(nrst), .wr_valid(wr_valid), .sw_reset(sw_reset),
   .downstream_resume(downstream_resume), .resume_detected_flag(resume_detected_flag),
   .remote_wakeup(remote_wakeup), .sof_start(sof_start), .root_hub_reset(root_hub_reset),
   .port_reset_signal(port_reset_signal), .host_functional_state(host_functional_state));
`default_nettype wire

//--- host_mode_control_test.sv
// Self-checking bench for host mode control
`timescale 1ns/1ns
`default_nettype none
module host_mode_control_test;
   localparam [16:0] DLY = 17'h00008;
   logic        ref_clk = 1'b0, nrst = 1'b0, sw_reset = 1'b0;
   logic        downstream_resume = 1'b0, resume_detected_flag = 1'b0;
   logic        cmd_valid, wr_valid, rd_valid, remote_wakeup, sof_start, sof_active;
   logic        root_hub_reset, port_reset_signal;
   logic [7:0]  cmd_code;
   logic [15:0] wr_data, rd_data;
   logic [1:0]  host_functional_state;
   logic [31:0] rd;
   int          errors = 0, cmp_count = 0, n;
   always #10 ref_clk = ~ref_clk;
   drv_model drv_model_inst (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .wr_valid(wr_valid), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data));
   host_mode_control #(.SOF_DELAY_CYCLES(DLY)) host_mode_control_inst (.ref_clk(ref_clk),
      .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
      .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .sw_reset(sw_reset),
      .downstream_resume(downstream_resume), .resume_detected_flag(resume_detected_flag),
      .remote_wakeup(remote_wakeup), .sof_start(sof_start), .sof_active(sof_active),
      .root_hub_reset(root_hub_reset), .port_reset_signal(port_reset_signal),
      .host_functional_state(host_functional_state));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_map;
      drv_model_inst.reg_read(8'h01, rd);
      check("ctrl at reset", rd, 32'h0000_0000);
      drv_model_inst.reg_write(8'h81, 32'hffff_ffff);
      drv_model_inst.reg_read(8'h01, rd);
      check("reserved masked", rd, 32'h0000_06c0);
      drv_model_inst.reg_write(8'h82, 32'h0000_0000);
      drv_model_inst.reg_read(8'h01, rd);
      check("foreign write", rd, 32'h0000_06c0);
      drv_model_inst.reg_read(8'h02, rd);
      check("foreign read", rd, 32'h0000_0000);
      $display("t_map done");
   endtask
   task automatic t_resume;
      @(posedge ref_clk) downstream_resume <= 1'b1;
      resume_detected_flag <= 1'b1;
      @(posedge ref_clk) downstream_resume <= 1'b0;
      #1 check("resume state", host_functional_state, 32'h1);
      check("wakeup on", remote_wakeup, 32'h1);
      $display("t_resume done");
   endtask
   task automatic t_sof;
      drv_model_inst.reg_write(8'h81, 32'h0000_0280);
      #1 check("wakeup off", remote_wakeup, 32'h0);
      n = 0;
      // Bounded wait; a lost frame start shows as a wrong count
      while (sof_start !== 1'b1 && n < 50) begin
         @(posedge ref_clk) #1 n++;
      end
      check("frame delay", n, 32'(DLY) + 32'h1);
      check("frames on", sof_active, 32'h1);
      @(posedge ref_clk) #1 check("frame pulse", sof_start, 32'h0);
      @(posedge ref_clk) downstream_resume <= 1'b1;
      @(posedge ref_clk) downstream_resume <= 1'b0;
      #1 check("no self move", host_functional_state, 32'h2);
      $display("t_sof done");
   endtask
   task automatic t_resets;
      drv_model_inst.reg_write(8'h81, 32'h0000_0680);
      @(posedge ref_clk) sw_reset <= 1'b1;
      @(posedge ref_clk) sw_reset <= 1'b0;
      #1 check("no hub reset", {root_hub_reset, port_reset_signal}, 32'h0);
      check("frames off", sof_active, 32'h0);
      check("wakeup cleared", remote_wakeup, 32'h0);
      drv_model_inst.reg_read(8'h01, rd);
      check("sw reset", rd, 32'h0000_0200);
      @(posedge ref_clk) nrst <= 1'b0;
      @(posedge ref_clk) nrst <= 1'b1;
      #1 check("hub reset", {root_hub_reset, port_reset_signal}, 32'h2);
      @(posedge ref_clk) #1;
      check("port reset", {root_hub_reset, port_reset_signal}, 32'h1);
      @(posedge ref_clk) #1;
      check("reset seq end", {root_hub_reset, port_reset_signal}, 32'h0);
      drv_model_inst.reg_read(8'h01, rd);
      check("hw reset", rd, 32'h0000_0000);
      $display("t_resets done");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      t_map;
      t_resume;
      t_sof;
      t_resets;
      end_of_test;
   end
   initial begin
      #20000;
      errors++;
      end_of_test;
   end
endmodule // host_mode_control_test
`default_nettype wire

//--- sof_delay_timer.v
// Start-of-frame delay timer
`timescale 1ns/1ns
`default_nettype none
`include "hc_ctrl_defines.vh"

module sof_delay_timer #(
   parameter [`SOF_CNT_W-1:0] DELAY_CYCLES = `SOF_DELAY_CYCLES
) (
   input  wire                  ref_clk,
   input  wire                  nrst,
   input  wire                  start,
   input  wire                  cancel,
   output reg                   done
);

   reg  [`SOF_CNT_W-1:0] count_r;
   reg                   run_r;

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count_r <= {`SOF_CNT_W{1'b0}};
         run_r   <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (cancel) begin
            run_r   <= 1'b0;
            count_r <= {`SOF_CNT_W{1'b0}};
         end else if (start) begin
            run_r   <= 1'b1;
            count_r <= DELAY_CYCLES - 1'b1;
         end else if (run_r) begin
            if (count_r == {`SOF_CNT_W{1'b0}}) begin
               run_r <= 1'b0;
               done  <= 1'b1;
            end else begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end

endmodule // sof_delay_timer
`default_nettype wire
